// ===== src/bmi_params.svh
// Constants for the byte move / increment executor: field positions, opcode
// patterns, reset values and cycle counts. Included by every file that uses them.
// Function
// - Add-one reads the addressed file register, adds one, writes the destination and updates zero.
// - Register-OR ORs the accumulator with the addressed file register, writes the destination and updates zero.
// - For add-one and register-OR a destination bit of 0 selects the accumulator and 1 the file register.
// - Copy-from-register updates zero from the moved value, so copying a register onto itself tests it for zero.
// - Copy-from-register delivers to the accumulator when the destination bit is 0 and to the same register when 1.
// - Copy-from-register is decoded from its pattern with destination bit and 7-bit address, one word, one cycle.
// - Store-accumulator is decoded from its pattern and copies the accumulator to the register with no flag change.
// - Load-literal is decoded from top bits 11 00xx and loads its 8-bit literal into the accumulator, no flag change.
`ifndef BMI_PARAMS_SVH
`define BMI_PARAMS_SVH

// Widths and instruction fields.
`define BMI_DATA_W      8
`define BMI_WORD_W      14
`define BMI_ADDR_W      7
`define BMI_FILE_DEPTH  128
`define BMI_DEST_BIT    7
`define BMI_ADDR_MSB    6
`define BMI_LIT_MSB     7

// Opcode patterns, compared against the top bits of the instruction word.
`define BMI_OPC6_ADD_ONE 6'h0a
`define BMI_OPC6_OR      6'h04
`define BMI_OPC6_COPY    6'h08
`define BMI_OPC7_STORE   7'h01
`define BMI_OPC4_LOAD    4'hc

// Reset values.
`define BMI_ACC_RST     8'h00
`define BMI_FILE_RST    8'h00
`define BMI_ZERO_RST    1'b0

// Every supported operation retires in this many enabled clock cycles.
`define BMI_OP_CYCLES   1

`endif

// ===== src/bmi_pkg.sv
// Types and the shared instruction decoder of the byte move / increment executor.
// Assumes bmi_params.svh is on the include path.
`include "bmi_params.svh"

package bmi_pkg;

   // Operations that this executor carries out; everything else is left alone.
   typedef enum logic [2:0] {
      bmi_op_none,
      bmi_op_add_one,
      bmi_op_or,
      bmi_op_copy,
      bmi_op_store,
      bmi_op_load
   } bmi_op_type;

   // Decodes one instruction word; used by the datapath and by its checks.
   function automatic bmi_op_type bmi_decode(input logic [`BMI_WORD_W-1:0] word);
      bmi_op_type op;
      op = bmi_op_none;
      if (word[13:8] == `BMI_OPC6_ADD_ONE) begin
         op = bmi_op_add_one;
      end else if (word[13:8] == `BMI_OPC6_OR) begin
         op = bmi_op_or;
      end else if (word[13:8] == `BMI_OPC6_COPY) begin
         op = bmi_op_copy;
      end else if (word[13:7] == `BMI_OPC7_STORE) begin
         op = bmi_op_store;
      end else if (word[13:10] == `BMI_OPC4_LOAD) begin
         op = bmi_op_load;
      end
      return op;
   endfunction

endpackage

// ===== src/bmi_exec.sv
// Executor for the add-one, register-OR, copy, store-accumulator and
// load-literal instructions, with its own 128-byte file and accumulator.
// Assumes instructions arrive from fetch logic on ref_clk, one per cycle.
`timescale 1ns/1ps
`include "bmi_params.svh"

module bmi_exec
   import bmi_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic                    ref_clk,
   input  wire logic                    reset,
   input  wire logic                    clk_en,
   // Instruction from fetch.
   input  wire logic                    instr_valid,
   input  wire logic [`BMI_WORD_W-1:0]  instr_word,
   // Debug read port into the file.
   input  wire logic [`BMI_ADDR_W-1:0]  dbg_addr,
   output logic      [`BMI_DATA_W-1:0]  dbg_data_ff,
   // Architectural state.
   output logic      [`BMI_DATA_W-1:0]  acc_ff,
   output logic                         zero_flag_ff,
   // Retire reporting.
   output logic                         done_ff,
   output logic                         zero_upd_ff,
   output logic                         unsupported_ff,
   // Mirror of each file write.
   output logic                         file_we_ff,
   output logic      [`BMI_ADDR_W-1:0]  file_addr_ff,
   output logic      [`BMI_DATA_W-1:0]  file_data_ff
);

   logic [`BMI_DATA_W-1:0] file_mem [`BMI_FILE_DEPTH];
   bmi_op_type             op;
   logic                   dest_file;
   logic [`BMI_ADDR_W-1:0] op_addr;
   logic [`BMI_DATA_W-1:0] op_lit;
   logic [`BMI_DATA_W-1:0] rd_val;
   logic [`BMI_DATA_W-1:0] nxt_result;
   logic                   nxt_to_acc;
   logic                   nxt_to_file;
   logic                   nxt_upd_zero;
   logic                   go;

   // Field extraction and the file read are combinational, so one cycle is enough.
   assign op        = bmi_decode(instr_word);
   assign dest_file = instr_word[`BMI_DEST_BIT];
   assign op_addr   = instr_word[`BMI_ADDR_MSB:0];
   assign op_lit    = instr_word[`BMI_LIT_MSB:0];
   assign rd_val    = file_mem[op_addr];
   assign go        = clk_en && instr_valid;

   // Result, destination and flag selection for each operation.
   always_comb begin
      nxt_result   = '0;
      nxt_to_acc   = 1'b0;
      nxt_to_file  = 1'b0;
      nxt_upd_zero = 1'b0;
      case (op)
         bmi_op_add_one: begin
            nxt_result   = rd_val + 8'h01;         // Eight bits wide, so it wraps.
            nxt_to_acc   = !dest_file;
            nxt_to_file  = dest_file;
            nxt_upd_zero = 1'b1;
         end
         bmi_op_or: begin
            nxt_result   = acc_ff | rd_val;
            nxt_to_acc   = !dest_file;
            nxt_to_file  = dest_file;
            nxt_upd_zero = 1'b1;
         end
         bmi_op_copy: begin
            nxt_result   = rd_val;
            nxt_to_acc   = !dest_file;
            nxt_to_file  = dest_file;
            nxt_upd_zero = 1'b1;
         end
         bmi_op_store: begin
            nxt_result   = acc_ff;
            nxt_to_file  = 1'b1;
         end
         bmi_op_load: begin
            nxt_result   = op_lit;
            nxt_to_acc   = 1'b1;
         end
         default: begin
            nxt_result   = '0;
         end
      endcase
   end

   // Accumulator update; an unsupported word leaves it alone.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         acc_ff <= `BMI_ACC_RST;
      end else if (go && nxt_to_acc) begin
         acc_ff <= nxt_result;
      end
   end

   // Zero flag: only the flag-updating operations touch it.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         zero_flag_ff <= `BMI_ZERO_RST;
      end else if (go && nxt_upd_zero) begin
         zero_flag_ff <= (nxt_result == 8'h00);
      end
   end

   // File storage; cleared on reset so a read never returns an unknown value.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         for (int i = 0; i < `BMI_FILE_DEPTH; i++) begin
            file_mem[i] <= `BMI_FILE_RST;
         end
      end else if (go && nxt_to_file) begin
         file_mem[op_addr] <= nxt_result;
      end
   end

   // Write mirror, so the surrounding datapath sees every store one cycle later.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         file_we_ff   <= 1'b0;
         file_addr_ff <= '0;
         file_data_ff <= '0;
      end else if (clk_en) begin
         file_we_ff <= instr_valid && nxt_to_file;
         if (instr_valid && nxt_to_file) begin
            file_addr_ff <= op_addr;
            file_data_ff <= nxt_result;
         end
      end
   end

   // Retire reporting. Every supported operation retires after one cycle.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         done_ff        <= 1'b0;
         zero_upd_ff    <= 1'b0;
         unsupported_ff <= 1'b0;
      end else if (clk_en) begin
         done_ff        <= instr_valid && (op != bmi_op_none);
         zero_upd_ff    <= instr_valid && nxt_upd_zero;
         unsupported_ff <= instr_valid && (op == bmi_op_none);
      end
   end

   // Registered debug read; it shows the file after the previous edge's write.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dbg_data_ff <= '0;
      end else if (clk_en) begin
         dbg_data_ff <= file_mem[dbg_addr];
      end
   end

   // Checks. Each one starts on an enabled edge and judges what is sampled at the
   // next edge, which already holds that edge's update whatever the enable does then;
   // chk_one_cycle fires only when that next edge is enabled and also judges the edge after.
   logic [`BMI_DATA_W-1:0] chk_mem_after;
   logic [`BMI_ADDR_W-1:0] chk_addr_ff;
   logic                   chk_go_add_acc;
   logic                   chk_go_add_file;

   // Address of the previous cycle, so a check can read back the byte just written.
   always_ff @(posedge ref_clk) begin
      chk_addr_ff <= op_addr;
   end

   assign chk_mem_after   = file_mem[chk_addr_ff];
   assign chk_go_add_acc  = go && (op == bmi_op_add_one) && !dest_file;
   assign chk_go_add_file = go && (op == bmi_op_add_one) && dest_file;

   chk_add_one_acc: assert property (
      @(posedge ref_clk) disable iff (reset)
      chk_go_add_acc |=> (acc_ff == 8'($past(rd_val) + 8'h01)) && done_ff
   ) else $error("add-one to accumulator gave the wrong value");

   chk_add_one_file: assert property (
      @(posedge ref_clk) disable iff (reset)
      chk_go_add_file |=> file_we_ff && (file_data_ff == 8'($past(rd_val) + 8'h01))
         && (acc_ff == $past(acc_ff))
   ) else $error("add-one to file did not write back or touched the accumulator");

   chk_add_one_wrap: assert property (
      @(posedge ref_clk) disable iff (reset)
      (go && (op == bmi_op_add_one) && (rd_val == 8'hff)) |=> zero_flag_ff
         && ($past(dest_file) ? (chk_mem_after == 8'h00) : (acc_ff == 8'h00))
   ) else $error("increment of 0xff did not wrap to zero");

   chk_or_result: assert property (
      @(posedge ref_clk) disable iff (reset)
      (go && (op == bmi_op_or) && !dest_file)
         |=> acc_ff == ($past(acc_ff) | $past(rd_val))
   ) else $error("register-OR gave the wrong accumulator value");

   chk_copy_zero: assert property (
      @(posedge ref_clk) disable iff (reset)
      (go && (op == bmi_op_copy))
         |=> (zero_flag_ff == ($past(rd_val) == 8'h00)) && zero_upd_ff
   ) else $error("copy did not set zero from the moved value");

   chk_copy_dest: assert property (
      @(posedge ref_clk) disable iff (reset)
      (go && (op == bmi_op_copy))
         |=> ($past(dest_file) ? (acc_ff == $past(acc_ff) && chk_mem_after == $past(rd_val))
                               : (acc_ff == $past(rd_val)))
   ) else $error("copy went to the wrong destination");

   chk_store_noflag: assert property (
      @(posedge ref_clk) disable iff (reset)
      (go && (op == bmi_op_store))
         |=> $stable(zero_flag_ff) && (chk_mem_after == $past(acc_ff)) && !zero_upd_ff
   ) else $error("store changed a flag or stored the wrong value");

   chk_load_literal: assert property (
      @(posedge ref_clk) disable iff (reset)
      (go && (op == bmi_op_load))
         |=> (acc_ff == $past(op_lit)) && $stable(zero_flag_ff) && !file_we_ff
   ) else $error("load-literal gave the wrong accumulator or changed a flag");

   chk_one_cycle: assert property (
      @(posedge ref_clk) disable iff (reset)
      (go && (op != bmi_op_none)) ##1 clk_en |-> done_ff ##1 (done_ff == $past(instr_valid && op != bmi_op_none))
   ) else $error("a supported operation did not retire in one cycle");

   chk_zero_rule: assert property (
      @(posedge ref_clk) disable iff (reset)
      (go && nxt_upd_zero) |=> zero_flag_ff == ($past(nxt_result) == 8'h00)
   ) else $error("zero flag disagrees with the result");

   cov_add_one_wrap: cover property (
      @(posedge ref_clk) disable iff (reset) chk_go_add_file && (rd_val == 8'hff));
   cov_copy_test: cover property (
      @(posedge ref_clk) disable iff (reset) go && (op == bmi_op_copy) && dest_file);
   cov_store_then_or: cover property (
      @(posedge ref_clk) disable iff (reset)
      (go && (op == bmi_op_store)) ##1 (go && (op == bmi_op_or)));
   cov_unsupported: cover property (
      @(posedge ref_clk) disable iff (reset) go && (op == bmi_op_none));

endmodule

// ===== test/bmi_exec_tb.sv
// Self-checking testbench for the byte move / increment executor.
// Assumes bmi_params.svh is on the include path and the design checks itself.
`timescale 1ns/1ps
`include "bmi_params.svh"

module bmi_exec_tb;
   logic        ref_clk, reset, clk_en, instr_valid;
   logic [13:0] instr_word;
   logic [6:0]  dbg_addr, file_addr_ff;
   logic [7:0]  dbg_data_ff, acc_ff, file_data_ff;
   logic        zero_flag_ff, done_ff, zero_upd_ff, unsupported_ff, file_we_ff;
   int          n_errors, samples_checked;

   bmi_exec dut_u (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
      .instr_valid(instr_valid), .instr_word(instr_word), .dbg_addr(dbg_addr),
      .dbg_data_ff(dbg_data_ff), .acc_ff(acc_ff), .zero_flag_ff(zero_flag_ff),
      .done_ff(done_ff), .zero_upd_ff(zero_upd_ff), .unsupported_ff(unsupported_ff),
      .file_we_ff(file_we_ff), .file_addr_ff(file_addr_ff), .file_data_ff(file_data_ff));

   // The 20 MHz core clock.
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Byte comparison; unknown bits never count as a match.
   task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // Flag and pulse comparison.
   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // Presents one word; valid stays up so that calls run back to back.
   task automatic exec(input logic [13:0] word);
      instr_valid = 1'b1;
      instr_word  = word;
      @(posedge ref_clk);
      #2;
   endtask

   // Drops valid for one cycle between scenarios.
   task automatic idle();
      instr_valid = 1'b0;
      @(posedge ref_clk);
      #2;
   endtask

   // Places a byte in the file through the accumulator.
   task automatic put(input logic [6:0] addr, input logic [7:0] val);
      exec({6'h30, val});
      exec({7'h01, addr});
   endtask

   // The debug port shows the file byte one cycle after the address.
   task automatic rd(input logic [6:0] addr, input logic [7:0] exp);
      dbg_addr = addr;
      @(posedge ref_clk);
      #2;
      chk_data(dbg_data_ff, exp);
   endtask

   task automatic t_load();
      exec({6'h30, 8'h5a});
      chk_data(acc_ff, 8'h5a);
      chk_bit(done_ff, 1'b1);
      chk_bit(zero_upd_ff, 1'b0);
      exec({4'hc, 2'b11, 8'ha5});
      chk_data(acc_ff, 8'ha5);
      chk_bit(file_we_ff, 1'b0);
      idle();
   endtask

   task automatic t_store();
      put(7'h0a, 8'h4f);
      chk_bit(file_we_ff, 1'b1);
      chk_data({1'b0, file_addr_ff}, 8'h0a);
      chk_data(file_data_ff, 8'h4f);
      chk_bit(zero_upd_ff, 1'b0);
      idle();
      rd(7'h0a, 8'h4f);
   endtask

   // Increment through the wrap in place, then increment the wrapped byte into the accumulator.
   task automatic t_inc();
      put(7'h05, 8'hff);
      exec({6'h0a, 1'b1, 7'h05});
      chk_data(file_data_ff, 8'h00);
      chk_bit(file_we_ff, 1'b1);
      chk_bit(zero_flag_ff, 1'b1);
      chk_bit(zero_upd_ff, 1'b1);
      chk_data(acc_ff, 8'hff);
      exec({6'h0a, 1'b0, 7'h05});
      chk_data(acc_ff, 8'h01);
      chk_bit(zero_flag_ff, 1'b0);
      chk_bit(file_we_ff, 1'b0);
      idle();
      rd(7'h05, 8'h00);
   endtask

   task automatic t_or();
      put(7'h06, 8'h30);
      exec({6'h30, 8'h0f});
      exec({6'h04, 1'b0, 7'h06});
      chk_data(acc_ff, 8'h3f);
      chk_bit(zero_flag_ff, 1'b0);
      chk_bit(file_we_ff, 1'b0);
      put(7'h07, 8'h00);
      exec({6'h04, 1'b1, 7'h07});
      chk_bit(file_we_ff, 1'b1);
      chk_data(file_data_ff, 8'h00);
      chk_bit(zero_flag_ff, 1'b1);
      idle();
   endtask

   // Copies rely on the file contents left by the OR scenario.
   task automatic t_copy();
      exec({6'h08, 1'b0, 7'h06});
      chk_data(acc_ff, 8'h30);
      chk_bit(zero_flag_ff, 1'b0);
      chk_bit(done_ff, 1'b1);
      exec({6'h08, 1'b1, 7'h07});
      chk_bit(file_we_ff, 1'b1);
      chk_data({1'b0, file_addr_ff}, 8'h07);
      chk_bit(zero_flag_ff, 1'b1);
      chk_data(acc_ff, 8'h30);
      idle();
   endtask

   // A store pattern with its marker bit clear must do nothing.
   task automatic t_unsup();
      exec(14'h0005);
      chk_bit(unsupported_ff, 1'b1);
      chk_bit(done_ff, 1'b0);
      chk_data(acc_ff, 8'h30);
      clk_en = 1'b0;
      exec({6'h30, 8'h11});
      chk_data(acc_ff, 8'h30);
      clk_en = 1'b1;
      idle();
   endtask

   task automatic test_done();
      $display("errors %0d, comparisons %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Main sequence: reset for six cycles, then each scenario in turn.
   initial begin
      n_errors = 0;
      samples_checked = 0;
      reset = 1'b1;
      clk_en = 1'b1;
      instr_valid = 1'b0;
      instr_word = 14'h0000;
      dbg_addr = 7'h00;
      repeat (6) @(posedge ref_clk);
      #2;
      reset = 1'b0;
      t_load();
      t_store();
      t_inc();
      t_or();
      t_copy();
      t_unsup();
      test_done();
   end

   // The tests need 33 cycles; 2000 cycles, about sixty times that, means a hang.
   initial begin
      #(2000 * 50);
      n_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, 1'b0, 1'b1);
      test_done();
   end
endmodule
